/* rtl/config_word_check_and_readback.sv */
`timescale 1ns/1ns
`include "cfg_consts.svh"
// Function
// (RULE1) Word-order bit 7: zero sends low half first, one sends high half first.
// (RULE2) Word order matters only when binary format bit 8 or 9 is set.
// (RULE3) Host writes zero into reserved bits 6 to 3 of the second word.
// (RULE4) Bits 2,1,0 set polarity of inputs 3,2,1; one means active on current.
// (RULE5) New standstill reduction takes effect only after the next move ends.
// (RULE6) Readback words 1 to 9 echo the accepted configuration words.
// (RULE7) Valid accepted configuration: readback word 0 echoes first config word.
// (RULE8) Unconfigured or invalid: readback word 0 carries the status word layout.
// (RULE9) At power-up without stored configuration, readback word 0 reads 6408h.
// (RULE10) Configuration mode: word 0 bit 13 shows stall checking enabled.
// (RULE11) Command mode: word 0 bit 13 shows a configuration error.
// (RULE12) Host qualifies word 0 bit 13 with bit 15 of that word.
// (RULE13) Any reserved bit set in any configuration word makes it invalid.
// (RULE14) Out-of-range parameter is invalid, such as speed low word above 999.
// (RULE15) Two or more inputs with the same function is invalid; the code lets general purpose repeat and allows the input 1/2 quadrature pair.
// (RULE16) Encoder requested without inputs 1 and 2 as quadrature is invalid.
// (RULE17) Encoder requested with encoder resolution word 6 unset is invalid.
// (RULE18) Stall checking without encoder use is invalid.
// (RULE19) Bit 15 of the first word selects configuration mode when one.
// (RULE20) Quadrature function allowed only on input 1 (A) and input 2 (B).
// (RULE21) Host sets encoder flag bit 10 as well as the quadrature functions.
// (RULE22) All checks run on each write; words stored only if all pass.
module config_word_check_and_readback
    import cfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire words_t      host_words_in,
    input  wire logic        cfg_write_in,
    input  wire logic [3:0]  rd_index_in,
    input  wire logic        move_done_in,
    input  wire logic [2:0]  input_current_in,
    output logic      [15:0] rd_data_out,
    output logic      [2:0]  input_active_out,
    output logic             big_endian_out,
    output logic             config_error_out,
    output logic             configured_out,
    output logic             mode_config_out,
    output logic      [15:0] idle_reduction_out
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cfg_state_t  state;
    words_t      stored;
    word1_t      w1_acc;
    word1_t      w1_new;
    logic [2:0]  fn1;
    logic [2:0]  fn2;
    logic [2:0]  fn3;
    logic        want_enc;
    logic        want_stall;
    logic        bad_rsvd;
    logic        bad_range;
    logic        bad_dup;
    logic        bad_enc_pins;
    logic        bad_enc_res;
    logic        bad_stall;
    logic        bad_quad_pin;
    logic        cfg_valid;
    logic        cfg_mode;
    logic        idle_pending;
    logic [15:0] status_word;
    logic [15:0] word0_view;
    logic [15:0] next_rd_data;

    // ----------------------------------------------------------------
    // Decode of the words now presented by the host
    // ----------------------------------------------------------------
    assign cfg_mode   = host_words_in[0][`CW_MODE_BIT]; // see (RULE19)
    assign w1_new     = word1_t'(host_words_in[1]);
    assign fn1        = host_words_in[0][`CW_IN1_LSB +: 3];
    assign fn2        = host_words_in[0][`CW_IN2_LSB +: 3];
    assign fn3        = host_words_in[0][`CW_IN3_LSB +: 3];
    assign want_enc   = host_words_in[0][`CW_ENC_BIT];
    assign want_stall = host_words_in[0][`CW_STALL_BIT];

    // Reserved bits in either configuration word
    assign bad_rsvd = |(host_words_in[0] & `CW_RSVD_MASK)
                    | (|w1_new.rsvd); // see (RULE13)

    // Starting speed low word carries only 0..999
    assign bad_range = host_words_in[`RB_SPEED_LO] > `SPEED_LO_MAX; // see (RULE14)

    // General purpose may repeat; quadrature pair is checked apart
    assign bad_dup = ((fn1 == fn2) && fn1 != `FN_GENERAL && fn1 != `FN_QUAD)
                   || ((fn1 == fn3) && fn1 != `FN_GENERAL)
                   || ((fn2 == fn3) && fn2 != `FN_GENERAL); // see (RULE15)

    assign bad_enc_pins = want_enc && !(fn1 == `FN_QUAD && fn2 == `FN_QUAD); // see (RULE16)
    assign bad_enc_res  = want_enc
                        && host_words_in[`RB_ENC_RES] == `ENC_RES_UNSET; // see (RULE17)
    assign bad_stall    = want_stall && !want_enc; // see (RULE18)

    // Quadrature never on input 3, and only with the encoder flag
    assign bad_quad_pin = (fn3 == `FN_QUAD)
                        || (!want_enc && (fn1 == `FN_QUAD || fn2 == `FN_QUAD)); // see (RULE20)

    // Every check is evaluated on the same write
    assign cfg_valid = !(bad_rsvd || bad_range || bad_dup || bad_enc_pins
                       || bad_enc_res || bad_stall || bad_quad_pin); // see (RULE22)

    // ----------------------------------------------------------------
    // Acceptance state
    // ----------------------------------------------------------------
    // Only writes made in configuration mode are judged
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= CFG_NONE; // see (RULE9)
        end
        else if (cfg_write_in && cfg_mode)
        begin
            state <= cfg_valid ? CFG_OK : CFG_BAD; // see (RULE22)
        end
    end

    // ----------------------------------------------------------------
    // Stored configuration words
    // ----------------------------------------------------------------
    // A failing write leaves the old set intact, never a partial update
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            stored <= '0;
        end
        else if (cfg_write_in && cfg_mode && cfg_valid)
        begin
            stored <= host_words_in; // see (RULE22)
        end
    end

    assign w1_acc = word1_t'(stored[1]);

    // ----------------------------------------------------------------
    // Standstill current reduction
    // ----------------------------------------------------------------
    // A move in progress keeps its old reduction until it ends
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            idle_pending <= 1'b0;
        end
        else if (cfg_write_in && cfg_mode && cfg_valid
                 && host_words_in[`RB_IDLE] != idle_reduction_out)
        begin
            idle_pending <= 1'b1; // see (RULE5)
        end
        else if (move_done_in)
        begin
            idle_pending <= 1'b0;
        end
    end

    // Applied value moves over on the end of the first move
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            idle_reduction_out <= `RST_WORD;
        end
        else if (move_done_in && idle_pending)
        begin
            idle_reduction_out <= stored[`RB_IDLE]; // see (RULE5)
        end
    end

    // ----------------------------------------------------------------
    // Word order and input polarity
    // ----------------------------------------------------------------
    // Endian bit is ignored while both binary formats are off
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            big_endian_out <= 1'b0;
        end
        else
        begin
            big_endian_out <= (w1_acc.in_fmt | w1_acc.out_fmt)
                              & w1_acc.big_endian; // see (RULE1) see (RULE2)
        end
    end

    // Active when current flow matches the polarity bit
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            input_active_out <= 3'h0;
        end
        else
        begin
            input_active_out <= input_current_in ~^ w1_acc.polarity; // see (RULE4)
        end
    end

    // ----------------------------------------------------------------
    // Readback words
    // ----------------------------------------------------------------
    // Status layout: bit 15 low, bit 13 flags the configuration error
    assign status_word = (state == CFG_OK) ? `STATUS_OK : `STATUS_UNCFG; // see (RULE9) see (RULE11)

    // Mirror only in configuration mode with an accepted set
    assign word0_view = (cfg_mode && state == CFG_OK) ? stored[0]
                                                      : status_word; // see (RULE7) see (RULE8) see (RULE10)

    // Unmapped indices read as zero
    always_comb
    begin
        next_rd_data = 16'h0000;
        if (rd_index_in == `RB_STATUS)
        begin
            next_rd_data = word0_view;
        end
        else if (rd_index_in <= `RB_LOOP_GAIN)
        begin
            next_rd_data = stored[rd_index_in]; // see (RULE6)
        end
    end

    // Registered read, one cycle after the index
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_data_out <= 16'h0000;
        end
        else
        begin
            rd_data_out <= next_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    assign config_error_out = (state != CFG_OK);
    assign configured_out   = (state == CFG_OK);
    assign mode_config_out  = cfg_mode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_good_write;
        cfg_write_in && cfg_mode && cfg_valid;
    endsequence

    sequence s_idle_change;
        cfg_write_in && cfg_mode && cfg_valid
        && host_words_in[`RB_IDLE] != idle_reduction_out;
    endsequence

    a_endian_select: assert property ( // see (RULE2)
        (!(w1_acc.in_fmt | w1_acc.out_fmt)) |=> !big_endian_out)
        else $error("word order set while binary formats are off");

    a_endian_follows: assert property ( // see (RULE1)
        $stable(stored[1]) && (w1_acc.in_fmt | w1_acc.out_fmt)
        |=> big_endian_out == $past(w1_acc.big_endian))
        else $error("word order does not follow endian bit");

    a_polarity_map: assert property ( // see (RULE4)
        $stable(stored[1]) |=> input_active_out
                               == ($past(input_current_in) ~^ $past(w1_acc.polarity)))
        else $error("input active level wrong");

    a_idle_delayed: assert property ( // see (RULE5)
        s_idle_change ##1 (!move_done_in)[*2] |-> $stable(idle_reduction_out))
        else $error("standstill reduction applied before move end");

    a_idle_applied: assert property ( // see (RULE5)
        idle_pending && move_done_in |=> idle_reduction_out == $past(stored[`RB_IDLE]))
        else $error("standstill reduction not applied at move end");

    a_echo_words: assert property ( // see (RULE6)
        rd_index_in == `RB_ENC_RES |=> rd_data_out == $past(stored[`RB_ENC_RES]))
        else $error("readback echo mismatch");

    a_word0_mirror: assert property ( // see (RULE7)
        s_good_write ##1 (cfg_mode && !cfg_write_in && rd_index_in == `RB_STATUS)
        |=> rd_data_out == $past(host_words_in[0], 2))
        else $error("word 0 does not mirror accepted word");

    a_word0_status: assert property ( // see (RULE8)
        (state != CFG_OK && rd_index_in == `RB_STATUS) |=> rd_data_out == `STATUS_UNCFG)
        else $error("word 0 lacks status layout");

    a_bad_rejected: assert property ( // see (RULE13)
        cfg_write_in && cfg_mode && bad_rsvd |=> config_error_out && $stable(stored))
        else $error("reserved bit accepted");

    a_speed_range: assert property ( // see (RULE14)
        cfg_write_in && cfg_mode && host_words_in[`RB_SPEED_LO] > `SPEED_LO_MAX
        |=> state == CFG_BAD)
        else $error("speed low word above limit accepted");

    a_stall_encoder: assert property ( // see (RULE18)
        cfg_write_in && cfg_mode && want_stall && !want_enc |=> !configured_out)
        else $error("stall without encoder accepted");

    a_bit13_mode: assert property ( // see (RULE10) see (RULE11)
        rd_index_in == `RB_STATUS && !cfg_write_in
        |=> rd_data_out[`CW_STALL_BIT] == ($past(cfg_mode) && $past(state) == CFG_OK
                                           ? $past(stored[0][`CW_STALL_BIT])
                                           : $past(state) != CFG_OK))
        else $error("word 0 bit 13 wrong for mode");

endmodule

/* rtl/cfg_consts.svh */
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

// ----------------------------------------------------------------
// Word counts and readback offsets
// ----------------------------------------------------------------
`define NUM_WORDS        10
`define RB_STATUS        4'h0
`define RB_WORD1         4'h1
`define RB_SPEED_HI      4'h2
`define RB_SPEED_LO      4'h3
`define RB_STEPS         4'h4
`define RB_STIFF         4'h5
`define RB_ENC_RES       4'h6
`define RB_IDLE          4'h7
`define RB_CURRENT       4'h8
`define RB_LOOP_GAIN     4'h9

// ----------------------------------------------------------------
// First configuration word fields
// ----------------------------------------------------------------
`define CW_MODE_BIT      15
`define CW_STALL_BIT     13
`define CW_ENC_BIT       10
`define CW_RSVD_MASK     16'h5a00
`define CW_IN1_LSB       0
`define CW_IN2_LSB       3
`define CW_IN3_LSB       6

// ----------------------------------------------------------------
// Second configuration word fields
// ----------------------------------------------------------------
`define W1_RSVD_MASK     16'h0078

// ----------------------------------------------------------------
// Input function codes and value limits
// ----------------------------------------------------------------
`define FN_GENERAL       3'h0
`define FN_QUAD          3'h7
`define SPEED_LO_MAX     16'h03e7
`define ENC_RES_UNSET    16'h0000

// ----------------------------------------------------------------
// Status word values and reset values
// ----------------------------------------------------------------
`define STATUS_UNCFG     16'h6408
`define STATUS_OK        16'h0000
`define RST_WORD         16'h0000

`endif

/* rtl/cfg_pkg.sv */
package cfg_pkg;

    // Second configuration word, bit 15 down to bit 0
    typedef struct packed {
        logic [5:0] upper;
        logic       in_fmt;
        logic       out_fmt;
        logic       big_endian;
        logic [3:0] rsvd;
        logic [2:0] polarity;
    } word1_t;

    // Ten network words as one carrier
    typedef logic [9:0][15:0] words_t;

    // Acceptance state of the stored configuration
    typedef enum logic [1:0] {
        CFG_NONE = 2'b00,
        CFG_OK   = 2'b01,
        CFG_BAD  = 2'b10
    } cfg_state_t;

endpackage

/* dv/host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------
module host_model
    import cfg_pkg::*;
(
    input  wire logic clk_in,
    output words_t    words_out,
    output logic      write_out
);
    // Idle host: all words zero, no strobe
    initial
    begin
        words_out = '0;
        write_out = 1'b0;
    end

    // Words stay in place after the strobe, since bit 15 of word 0 keeps
    // steering the readback word 0 long after the write itself
    task automatic send(input words_t w, input logic pulse);
        @(negedge clk_in);
        words_out = w;
        write_out = pulse;
        @(negedge clk_in);
        write_out = 1'b0;
    endtask

    // Bit 13 is trusted only in the mode that bit 15 names
    function automatic logic error_seen(input logic [15:0] w0);
        return !w0[15] && w0[13];
    endfunction
endmodule

/* dv/tb.sv */
`timescale 1ns/1ns
`include "cfg_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb
    import cfg_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    words_t      host_words;
    logic        cfg_write;
    logic [3:0]  rd_index = 4'h0;
    logic        move_done = 1'b0;
    logic [2:0]  input_current = 3'h0;
    logic [15:0] rd_data;
    logic [2:0]  input_active;
    logic        big_endian;
    logic        config_error;
    logic        configured;
    logic        mode_config;
    logic [15:0] idle_reduction;
    words_t      m_w = '0;
    words_t      base;
    words_t      w;
    int          m_ok = 0;
    int          m_pend = 0;
    logic [15:0] m_idle = 16'h0000;
    int          miscompares = 0;
    int          compares = 0;

    // ----------------------------------------------------------------
    // Clock, host and design
    // ----------------------------------------------------------------
    always #5 clk_in = ~clk_in;

    host_model host_i (.clk_in(clk_in), .words_out(host_words), .write_out(cfg_write));

    config_word_check_and_readback config_word_check_and_readback_i (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .host_words_in(host_words),
        .cfg_write_in(cfg_write), .rd_index_in(rd_index), .move_done_in(move_done),
        .input_current_in(input_current), .rd_data_out(rd_data),
        .input_active_out(input_active), .big_endian_out(big_endian),
        .config_error_out(config_error), .configured_out(configured),
        .mode_config_out(mode_config), .idle_reduction_out(idle_reduction));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    // Every check runs on every write, so one bad field rejects the set
    function automatic bit valid_cfg(input words_t c);
        int f1;
        int f2;
        int f3;
        bit enc;
        bit ok;
        f1 = c[0][2:0];
        f2 = c[0][5:3];
        f3 = c[0][8:6];
        enc = c[0][10];
        ok = ((c[0] & `CW_RSVD_MASK) == 0) && ((c[1] & `W1_RSVD_MASK) == 0);
        ok &= c[3] <= `SPEED_LO_MAX;
        ok &= enc ? (f1 == 7 && f2 == 7 && f3 != 7) : (f1 != 7 && f2 != 7 && f3 != 7);
        ok &= !((f1 == f2 && f1 != 0 && !enc) || (f1 == f3 && f1 != 0) || (f2 == f3 && f2 != 0));
        ok &= !(enc && c[6] == `ENC_RES_UNSET);
        ok &= !(c[0][13] && !enc);
        return ok;
    endfunction

    function automatic logic [15:0] exp_rd(input int i);
        if (i > 9) return 16'h0000;
        if (i > 0) return m_w[i];
        if (host_words[0][15] && m_ok == 1) return m_w[0];
        return (m_ok == 1) ? 16'h0000 : 16'h6408;
    endfunction

    // ----------------------------------------------------------------
    // Stimulus and checks
    // ----------------------------------------------------------------
    task automatic put(input words_t c, input logic pulse);
        host_i.send(c, pulse);
        if (pulse && c[0][15])
        begin
            if (valid_cfg(c))
            begin
                m_w = c;
                m_ok = 1;
                m_pend = (c[7] != m_idle);
            end
            else
                m_ok = 2;
        end
    endtask

    task automatic check_flags;
        @(negedge clk_in);
        `CHK("configured", m_ok == 1, configured)
        `CHK("config_error", m_ok != 1, config_error)
        `CHK("mode_config", host_words[0][15], mode_config)
        `CHK("big_endian", (m_w[1][8] | m_w[1][9]) & m_w[1][7], big_endian)
        `CHK("idle_reduction", m_idle, idle_reduction)
    endtask

    task automatic check_reads;
        for (int i = 0; i < 16; i++)
        begin
            rd_index = i[3:0];
            @(negedge clk_in);
            @(negedge clk_in);
            `CHK("readback", exp_rd(i), rd_data)
            if (i == 0 && !host_words[0][15])
                `CHK("error_bit", m_ok != 1, host_i.error_seen(rd_data))
        end
        // Park on word 0 so the next write is followed by a word 0 read
        rd_index = 4'h0;
    endtask

    task automatic move;
        @(negedge clk_in);
        move_done = 1'b1;
        @(negedge clk_in);
        move_done = 1'b0;
        if (m_pend) m_idle = m_w[7];
        m_pend = 0;
    endtask

    task automatic summarize;
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog, far beyond the under two thousand cycles the tests take
    initial
    begin
        #200000;
        miscompares++;
        summarize();
    end

    // Main sequence
    initial
    begin
        logic [15:0] bad [12][2];
        void'($urandom(32'h4eed5050));
        bad = '{'{0, 16'he43f}, '{0, 16'hb43f}, '{0, 16'ha83f}, '{0, 16'ha63f},
                '{1, 16'h038d}, '{1, 16'h03c5}, '{3, 16'd1000}, '{6, 16'h0000},
                '{0, 16'ha438}, '{0, 16'ha011}, '{0, 16'h8009}, '{0, 16'h81c0}};
        base = '{16'h4, 16'd30, 16'd50, 16'd1000, 16'h3, 16'd200, 16'd999,
                 16'h1, 16'h0385, 16'ha43f};
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'b1;
        check_flags();
        check_reads();
        put(base, 1'b1);
        check_flags();
        check_reads();
        // Polarity follows current through the stored level bits
        for (int k = 0; k < 8; k++)
        begin
            input_current = k[2:0];
            repeat (2) @(negedge clk_in);
            `CHK("input_active", ~(input_current ^ m_w[1][2:0]), input_active)
        end
        move();
        check_flags();
        for (int k = 0; k < 12; k++)
        begin
            w = base;
            w[bad[k][0]] = bad[k][1];
            put(w, 1'b1);
            check_flags();
            check_reads();
            w = base;
            w[7] = w[7] + k[15:0] + 16'h1;
            put(w, 1'b1);
            check_flags();
        end
        for (int k = 0; k < 8; k++)
        begin
            w = base;
            w[1][9:7] = k[2:0];
            put(w, 1'b1);
            check_flags();
        end
        w[0][15] = 1'b0;
        put(w, 1'b0);
        check_reads();
        w[7] = 16'h0077;
        put(w, 1'b1);
        check_flags();
        check_reads();
        move();
        check_flags();
        for (int k = 0; k < 150; k++)
        begin
            w = '0;
            for (int j = 0; j < 10; j++) w[j] = 16'($urandom);
            w[0] = 16'h8000 | (w[0] & ((k % 4 == 0) ? 16'h7fff : 16'h25ff));
            w[1] = (k % 5 == 0) ? w[1] : (w[1] & 16'hff87);
            w[3] = 16'($urandom % 1100);
            input_current = 3'($urandom);
            put(w, 1'b1);
            check_flags();
            if (k % 3 == 0) move();
            if (k % 10 == 0) check_reads();
        end
        summarize();
    end
endmodule
